// file: src/rsm_top.sv
/*
 Reset and supply monitor: cause gathering, reset sequencing, cause flags,
 brownout and low-supply warning control, power control value.
 Assumes comparator inputs are asynchronous and the watchdog, debug and
 wake inputs come from logic on mclk.
*/
// Chosen here: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module rsm_top
    import rsm_pkg::*;
#(
    parameter logic [RSM_CNT_W-1:0] CFG_CYC  = RSM_CFG_CYC,
    parameter logic [RSM_CNT_W-1:0] STAB_CYC = RSM_STAB_CYC
)
(
    // Clock, reset, enable
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        ce,
    // Register port
    input  wire logic [7:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [7:0]  rdata,
    // Reset sources
    input  wire logic        external_reset_pin,
    input  wire logic        watchdog_overflow,
    input  wire logic        watchdog_enable,
    input  wire logic        debug_reset_req,
    input  wire logic        brownout_below,
    // Low-supply warning comparator
    input  wire logic        warn_below,
    // Wake from idle or stop
    input  wire logic        wake_event,
    // Reset outputs
    output logic             sys_rst_n,
    output logic             config_read,
    output logic      [15:0] reset_vector,
    output logic             ext_pin_pullup_en,
    // Analog controls
    output logic             brownout_detector_en,
    output logic      [3:0]  brownout_threshold_sel,
    output logic             low_supply_warn_enable,
    output logic      [3:0]  low_supply_warn_level,
    output logic             warn_external_reference,
    // Power modes
    output logic             stop_mode,
    output logic             idle_mode
);

    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] off);
        hit = (a == off);
    endfunction

    function automatic logic code_ok(input logic [3:0] code,
                                     input logic [3:0] max);
        code_ok = (code <= max);
    endfunction

    rsm_state_t           state_reg;
    logic [RSM_CNT_W-1:0] cnt_reg;
    logic                 cfg_pend_reg;
    logic                 cfg_read_reg;
    logic [7:0]           flags_reg;
    logic [7:0]           flags_next;
    logic [7:0]           brown_reg;
    logic [7:0]           warn_reg;
    logic [7:0]           pctl_reg;
    logic [7:0]           rdata_reg;
    logic [2:0]           bo_sync_reg;
    logic [2:0]           wl_sync_reg;
    logic                 bo_lvl_reg;
    logic                 wl_lvl_reg;
    logic                 pin_filt;
    logic                 cause_pin;
    logic                 cause_wdt;
    logic                 cause_bo;
    logic                 cause_dbg;
    logic                 any_cause;
    logic                 stop_release;
    logic                 wake_clear;
    logic [7:0]           set_vec;

    rsm_pin_filter u_pin_filter (
        .mclk     (mclk),
        .rstn     (rstn),
        .ce       (ce),
        .pin_in   (external_reset_pin),
        .pin_filt (pin_filt)
    );

    // Comparator outputs cross in from the analog side
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            bo_sync_reg <= 3'h0;
            wl_sync_reg <= 3'h0;
            bo_lvl_reg  <= 1'b0;
            wl_lvl_reg  <= 1'b0;
        end
        else if (ce)
        begin
            bo_sync_reg <= {bo_sync_reg[1:0], brownout_below};
            wl_sync_reg <= {wl_sync_reg[1:0], warn_below};
            if (bo_sync_reg[2] == bo_sync_reg[1])
                bo_lvl_reg <= bo_sync_reg[2];
            if (wl_sync_reg[2] == wl_sync_reg[1])
                wl_lvl_reg <= wl_sync_reg[2];
        end
    end

    // Cause qualification
    assign cause_pin = !pin_filt;
    assign cause_wdt = watchdog_overflow && watchdog_enable;
    assign cause_bo  = bo_lvl_reg && !brown_reg[RSM_B_DISABLE];
    assign cause_dbg = debug_reset_req;
    assign any_cause = cause_pin || cause_wdt || cause_bo || cause_dbg;

    // Sequencer: hold while a cause lasts, then stabilise and process
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= RSM_STAB;
            cnt_reg   <= '0;
        end
        else if (ce)
        begin
            if (any_cause)
            begin
                state_reg <= RSM_HOLD;
                cnt_reg   <= '0;
            end
            else
            begin
                case (state_reg)
                    RSM_HOLD:
                    begin
                        state_reg <= RSM_STAB;
                        cnt_reg   <= '0;
                    end
                    RSM_STAB:
                    begin
                        if (cnt_reg == STAB_CYC - 1'b1)
                        begin
                            state_reg <= RSM_PROC;
                            cnt_reg   <= '0;
                        end
                        else
                            cnt_reg <= cnt_reg + 1'b1;
                    end
                    RSM_PROC:
                    begin
                        if (cnt_reg == RSM_PROC_CYC - 1'b1)
                        begin
                            state_reg <= RSM_RUN;
                            cnt_reg   <= '0;
                        end
                        else
                            cnt_reg <= cnt_reg + 1'b1;
                    end
                    RSM_RUN:
                        state_reg <= RSM_RUN;
                    default:
                    begin
                        state_reg <= RSM_HOLD;
                        cnt_reg   <= '0;
                    end
                endcase
            end
        end
    end

    // Configuration read; a brownout also asks for a fresh read
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            cfg_pend_reg <= 1'b1;
            cfg_read_reg <= 1'b0;
        end
        else if (ce)
        begin
            cfg_read_reg <= 1'b0;
            if (cause_bo)
                cfg_pend_reg <= 1'b1;
            else if (state_reg == RSM_STAB && cfg_pend_reg
                     && cnt_reg == CFG_CYC - 1'b1)
            begin
                cfg_read_reg <= 1'b1;
                cfg_pend_reg <= 1'b0;
            end
        end
    end

    // Cause flags: hardware set wins over a software clear
    always_comb
    begin
        set_vec            = 8'h00;
        set_vec[RSM_B_PIN] = cause_pin;
        set_vec[RSM_B_WDT] = cause_wdt;
        set_vec[RSM_B_DBG] = cause_dbg;
        set_vec[RSM_B_BO]  = cause_bo;
        flags_next = flags_reg;
        if (wr && hit(addr, RSM_OFF_FLAGS))
            flags_next = flags_reg & ~(~wdata & RSM_FLAGS_MASK);
        flags_next = flags_next | set_vec;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            flags_reg <= RSM_FLAGS_RST;
        else if (ce)
            flags_reg <= flags_next;
    end

    // Power control value; wake or reset ends idle and stop
    assign stop_mode    = (pctl_reg == RSM_PCTL_STOP);
    assign idle_mode    = (pctl_reg == RSM_PCTL_IDLE);
    assign wake_clear   = wake_event && (stop_mode || idle_mode);
    assign stop_release = wake_event && stop_mode;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            pctl_reg <= RSM_PCTL_RST;
        else if (ce)
        begin
            if (any_cause || wake_clear)
                pctl_reg <= RSM_PCTL_RST;
            else if (wr && hit(addr, RSM_OFF_PCTL))
                pctl_reg <= wdata & RSM_PCTL_MASK;
        end
    end

    // Brownout control; threshold survives every reset but power-up
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            brown_reg <= RSM_BROWN_RST;
        else if (ce)
        begin
            if (any_cause)
            begin
                brown_reg[RSM_B_REARM]   <= 1'b0;
                brown_reg[RSM_B_DISABLE] <= 1'b0;
            end
            else
            begin
                if (wr && hit(addr, RSM_OFF_BROWN))
                begin
                    brown_reg[RSM_B_REARM]   <= wdata[RSM_B_REARM];
                    brown_reg[RSM_B_DISABLE] <= wdata[RSM_B_DISABLE];
                    // Invalid codes are dropped so the detector never
                    // sees an unspecified trip level
                    if (code_ok(wdata[RSM_B_THR_HI:RSM_B_THR_LO],
                                RSM_THR_MAX))
                        brown_reg[RSM_B_THR_HI:RSM_B_THR_LO] <=
                            wdata[RSM_B_THR_HI:RSM_B_THR_LO];
                end
                if (stop_release && brown_reg[RSM_B_REARM])
                    brown_reg[RSM_B_DISABLE] <= 1'b0;
            end
        end
    end

    // Low-supply warning; flag set wins over a software clear
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            warn_reg <= RSM_WARN_RST;
        else if (ce)
        begin
            if (any_cause)
                warn_reg <= RSM_WARN_RST;
            else
            begin
                if (wr && hit(addr, RSM_OFF_WARN))
                begin
                    warn_reg[RSM_B_WEN] <= wdata[RSM_B_WEN];
                    if (!wdata[RSM_B_WFLAG])
                        warn_reg[RSM_B_WFLAG] <= 1'b0;
                    if (code_ok(wdata[RSM_B_LVL_HI:RSM_B_LVL_LO],
                                RSM_LVL_MAX))
                        warn_reg[RSM_B_LVL_HI:RSM_B_LVL_LO] <=
                            wdata[RSM_B_LVL_HI:RSM_B_LVL_LO];
                end
                if (warn_reg[RSM_B_WEN] && wl_lvl_reg)
                    warn_reg[RSM_B_WFLAG] <= 1'b1;
            end
        end
    end

    // Read port; data valid only in the cycle after the strobe
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            rdata_reg <= 8'h00;
        else if (ce)
        begin
            rdata_reg <= 8'h00;
            if (rd)
            begin
                case (addr)
                    RSM_OFF_FLAGS: rdata_reg <= flags_reg;
                    RSM_OFF_PCTL:  rdata_reg <= pctl_reg;
                    RSM_OFF_WARN:  rdata_reg <= warn_reg;
                    RSM_OFF_BROWN: rdata_reg <= brown_reg;
                    default:       rdata_reg <= 8'h00;
                endcase
            end
        end
    end

    assign rdata                   = rdata_reg;
    assign sys_rst_n               = (state_reg == RSM_RUN);
    assign config_read             = cfg_read_reg;
    assign reset_vector            = RSM_RESET_VECTOR;
    assign ext_pin_pullup_en       = 1'b1;
    assign brownout_detector_en    = !brown_reg[RSM_B_DISABLE];
    assign brownout_threshold_sel  = brown_reg[RSM_B_THR_HI:RSM_B_THR_LO];
    assign low_supply_warn_enable  = warn_reg[RSM_B_WEN];
    assign low_supply_warn_level   = warn_reg[RSM_B_LVL_HI:RSM_B_LVL_LO];
    assign warn_external_reference =
        (warn_reg[RSM_B_LVL_HI:RSM_B_LVL_LO] == RSM_LVL_EXT_REF);

    a_release_path: assert property (@(posedge mclk) disable iff (!rstn)
        $rose(sys_rst_n) |-> $past(state_reg) == RSM_PROC)
        else $error("reset released without processing step");

    // A new cause restarts the sequence, so it cuts the step short legally
    a_proc_length: assert property (@(posedge mclk)
        disable iff (!rstn || !ce || any_cause)
        $rose(state_reg == RSM_PROC) |->
            (state_reg == RSM_PROC)[*5] ##1 state_reg != RSM_PROC)
        else $error("processing step not five clocks");

    a_bo_qualify: assert property (@(posedge mclk) disable iff (!rstn)
        (ce && bo_lvl_reg && brown_reg[RSM_B_DISABLE] && !cause_pin
         && !cause_wdt && !cause_dbg && state_reg == RSM_RUN)
        |=> state_reg == RSM_RUN)
        else $error("disabled brownout caused a reset");

    a_cause_hold: assert property (@(posedge mclk) disable iff (!rstn)
        (ce && any_cause) |=> state_reg == RSM_HOLD && !sys_rst_n)
        else $error("reset cause did not hold reset");

    a_flag_set_wins: assert property (@(posedge mclk) disable iff (!rstn)
        (ce && cause_wdt && wr && hit(addr, RSM_OFF_FLAGS))
        |=> flags_reg[RSM_B_WDT])
        else $error("watchdog flag lost to a clear");

    a_flag_keep: assert property (@(posedge mclk) disable iff (!rstn)
        (ce && cause_pin && !wr && !cause_wdt)
        |=> flags_reg[RSM_B_WDT] == $past(flags_reg[RSM_B_WDT]))
        else $error("pin reset disturbed another flag");

    a_por_clear: assert property (@(posedge mclk) disable iff (!rstn)
        (ce && wr && hit(addr, RSM_OFF_FLAGS) && !wdata[RSM_B_POR])
        |=> !flags_reg[RSM_B_POR])
        else $error("power-up flag not cleared");

    a_thr_invalid: assert property (@(posedge mclk) disable iff (!rstn)
        (ce && !any_cause && wr && hit(addr, RSM_OFF_BROWN)
         && wdata[RSM_B_THR_HI:RSM_B_THR_LO] > RSM_THR_MAX)
        |=> $stable(brownout_threshold_sel))
        else $error("invalid threshold code stored");

    a_thr_retain: assert property (@(posedge mclk) disable iff (!rstn)
        (ce && any_cause) |=> $stable(brownout_threshold_sel))
        else $error("threshold lost on a non power-up reset");

    a_rearm_wake: assert property (@(posedge mclk) disable iff (!rstn)
        (ce && stop_release && brown_reg[RSM_B_REARM])
        |=> brownout_detector_en)
        else $error("stop release did not re-arm brownout");

    a_warn_set: assert property (@(posedge mclk) disable iff (!rstn)
        (ce && !any_cause && low_supply_warn_enable && wl_lvl_reg)
        |=> warn_reg[RSM_B_WFLAG])
        else $error("warning flag not set");

    a_wake_clear: assert property (@(posedge mclk) disable iff (!rstn)
        (ce && wake_event && stop_mode) |=> pctl_reg == RSM_PCTL_RST)
        else $error("wake did not clear power control");

    c_power_up_run: cover property (@(posedge mclk) disable iff (!rstn)
        $rose(sys_rst_n));
    c_config_read: cover property (@(posedge mclk) disable iff (!rstn)
        config_read);
    c_brownout_rst: cover property (@(posedge mclk) disable iff (!rstn)
        cause_bo && sys_rst_n);
    c_stop_release: cover property (@(posedge mclk) disable iff (!rstn)
        stop_release && brown_reg[RSM_B_REARM]);

endmodule // rsm_top
`default_nettype wire

// file: include/rsm_pkg.sv
/*
 Constants, register map and types of the reset and supply monitor.
 Assumes an 8-bit register port and a 20 MHz system clock.
*/
`default_nettype none
package rsm_pkg;

    // Register offsets
    localparam logic [7:0] RSM_OFF_FLAGS = 8'h86;
    localparam logic [7:0] RSM_OFF_PCTL  = 8'h87;
    localparam logic [7:0] RSM_OFF_WARN  = 8'hE1;
    localparam logic [7:0] RSM_OFF_BROWN = 8'hF7;

    // Reset values and masks
    localparam logic [7:0] RSM_FLAGS_RST  = 8'h88;
    localparam logic [7:0] RSM_FLAGS_MASK = 8'hF8;
    localparam logic [7:0] RSM_WARN_RST   = 8'h00;
    localparam logic [7:0] RSM_BROWN_RST  = 8'h00;
    localparam logic [7:0] RSM_PCTL_RST   = 8'h00;
    localparam logic [7:0] RSM_PCTL_MASK  = 8'h8F;
    localparam logic [7:0] RSM_PCTL_STOP  = 8'h03;
    localparam logic [7:0] RSM_PCTL_IDLE  = 8'h01;

    // Flag bit positions
    localparam int RSM_B_POR = 7;
    localparam int RSM_B_PIN = 6;
    localparam int RSM_B_WDT = 5;
    localparam int RSM_B_DBG = 4;
    localparam int RSM_B_BO  = 3;

    // Brownout control fields
    localparam int RSM_B_REARM   = 7;
    localparam int RSM_B_THR_HI  = 4;
    localparam int RSM_B_THR_LO  = 1;
    localparam int RSM_B_DISABLE = 0;

    // Warning control fields
    localparam int RSM_B_WFLAG  = 5;
    localparam int RSM_B_WEN    = 4;
    localparam int RSM_B_LVL_HI = 3;
    localparam int RSM_B_LVL_LO = 0;

    // Level codes
    localparam logic [3:0] RSM_THR_MAX     = 4'hD;
    localparam logic [3:0] RSM_LVL_MAX     = 4'hD;
    localparam logic [3:0] RSM_LVL_EXT_REF = 4'hD;

    localparam logic [15:0] RSM_RESET_VECTOR = 16'h0000;

    // Timing
    localparam int RSM_MCLK_MHZ    = 20;
    localparam int RSM_IRC_MHZ     = 8;
    localparam int RSM_IRC_DIV     = 8;
    localparam int RSM_BIT_PRESC   = 256;
    localparam int RSM_CFG_TICKS   = 'h28;
    localparam int RSM_CFG_TIME_NS =
        (RSM_IRC_DIV * RSM_BIT_PRESC * RSM_CFG_TICKS * 1000) / RSM_IRC_MHZ;
    localparam int RSM_STAB_TIME_US = 16000;
    localparam int RSM_FILT_TIME_NS = 2000;
    localparam int RSM_PROC_CLOCKS  = 5;

    localparam int RSM_CNT_W  = 20;
    localparam int RSM_FILT_W = 6;

    localparam logic [RSM_CNT_W-1:0] RSM_CFG_CYC =
        RSM_CNT_W'((RSM_CFG_TIME_NS * RSM_MCLK_MHZ + 999) / 1000);
    localparam logic [RSM_CNT_W-1:0] RSM_STAB_CYC =
        RSM_CNT_W'(RSM_STAB_TIME_US * RSM_MCLK_MHZ);
    localparam logic [RSM_CNT_W-1:0] RSM_PROC_CYC =
        RSM_CNT_W'(RSM_PROC_CLOCKS);
    localparam logic [RSM_FILT_W-1:0] RSM_FILT_CYC =
        RSM_FILT_W'((RSM_FILT_TIME_NS * RSM_MCLK_MHZ + 999) / 1000);

    typedef enum logic [1:0] {
        RSM_HOLD = 2'h0,
        RSM_STAB = 2'h1,
        RSM_PROC = 2'h2,
        RSM_RUN  = 2'h3
    } rsm_state_t;

endpackage
`default_nettype wire

// file: src/rsm_pin_filter.sv
/*
 Reset pin synchroniser and glitch filter.
 Assumes the pin is asynchronous to mclk and idles high.
*/
`timescale 1ns/100ps
`default_nettype none
module rsm_pin_filter
    import rsm_pkg::*;
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic ce,
    // Pin and filtered level
    input  wire logic pin_in,
    output logic      pin_filt
);

    logic [2:0]            sync_reg;
    logic                  agree_reg;
    logic                  filt_reg;
    logic [RSM_FILT_W-1:0] cnt_reg;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            sync_reg  <= 3'h7;
            agree_reg <= 1'b1;
        end
        else if (ce)
        begin
            sync_reg <= {sync_reg[1:0], pin_in};
            if (sync_reg[2] == sync_reg[1])
                agree_reg <= sync_reg[2];
        end
    end

    // Level must differ for the full window before it is taken
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            filt_reg <= 1'b1;
            cnt_reg  <= '0;
        end
        else if (ce)
        begin
            if (agree_reg == filt_reg)
                cnt_reg <= '0;
            else if (cnt_reg == RSM_FILT_CYC - 1'b1)
            begin
                filt_reg <= agree_reg;
                cnt_reg  <= '0;
            end
            else
                cnt_reg <= cnt_reg + 1'b1;
        end
    end

    assign pin_filt = filt_reg;

    a_short_pulse: assert property (@(posedge mclk) disable iff (!rstn)
        $fell(filt_reg) |-> $past(cnt_reg) == RSM_FILT_CYC - 1'b1)
        else $error("pin filter passed a short pulse");

    c_pin_low: cover property (@(posedge mclk) disable iff (!rstn)
        $fell(filt_reg));

endmodule // rsm_pin_filter
`default_nettype wire

// file: test/rsm_rail_model.sv
/*
 Reset pin driver and supply rail model.
 Assumes the bench requests pin pulls and supply sags.
*/
`timescale 1ns/100ps
`default_nettype none
module rsm_rail_model
(
    // Requests
    input  wire logic pull_low,
    input  wire logic sag,
    // Pin and comparator
    output logic      pin,
    output logic      below
);
    // Released pin rests at the pull-up level, never at a stale value
    assign pin   = !pull_low;
    assign below = sag;
endmodule // rsm_rail_model
`default_nettype wire

// file: test/tb_rsm_top.sv
/*
 Bench for the reset and supply monitor.
 Assumes shortened configuration and stabilisation counts.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_rsm_top
    import rsm_pkg::*;
;
    localparam int CFG = 20;
    localparam int STB = 50;
    logic        mclk, rstn, wr, rd, wdo, wde, dbg, pull, sag, wbl, wake;
    logic [7:0]  addr, wdata, rdata;
    logic [15:0] vec;
    logic        srst, cfg, pu, boen, wen, wref, stp, idl, ce;
    logic [3:0]  thr, lvl;
    wire logic   pin, bbl;
    int          mismatches, n_checks, cyc, n;

    rsm_rail_model i_rsm_rail_model (.pull_low(pull), .sag(sag), .pin(pin),
        .below(bbl));
    rsm_top #(.CFG_CYC(RSM_CNT_W'(CFG)), .STAB_CYC(RSM_CNT_W'(STB))) i_rsm_top
    (
        .mclk(mclk), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .external_reset_pin(pin),
        .watchdog_overflow(wdo), .watchdog_enable(wde),
        .debug_reset_req(dbg), .brownout_below(bbl), .warn_below(wbl),
        .wake_event(wake), .sys_rst_n(srst), .config_read(cfg),
        .reset_vector(vec), .ext_pin_pullup_en(pu),
        .brownout_detector_en(boen), .brownout_threshold_sel(thr),
        .low_supply_warn_enable(wen), .low_supply_warn_level(lvl),
        .warn_external_reference(wref), .stop_mode(stp), .idle_mode(idl));

    initial
    begin
        mclk = 1'h0;
        forever #25 mclk = ~mclk;
    end

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_checks++;
        if (s !== e)
        begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk); wr <= 1'h1; addr <= a; wdata <= d;
        @(posedge mclk); wr <= 1'h0;
    endtask

    // Read data is looked at only in the single cycle it stands
    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk); rd <= 1'h1; addr <= a;
        @(posedge mclk); rd <= 1'h0;
        #1 chk(rdata, e);
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge mclk);
        #1;
    endtask

    // Bounded wait for release of the internal reset
    task automatic wait_run(output int k);
        k = 0;
        #1;
        while (srst !== 1'h1 && k < 400)
        begin
            @(posedge mclk); #1 k++;
        end
    endtask

    task automatic t_por;
        n = 0;
        while (cfg !== 1'h1 && n < 400)
        begin
            @(posedge mclk); #1 n++;
        end
        chk(n >= CFG && n <= CFG + 2, 1'h1);
        wait_run(n);
        chk(srst, 1'h1);
        chk(vec, 16'h0000);
        chk(pu, 1'h1);
        rreg(RSM_OFF_FLAGS, 8'h88);
        rreg(RSM_OFF_BROWN, 8'h00);
        rreg(8'h40, 8'h00);
        wreg(RSM_OFF_FLAGS, 8'h00);
        rreg(RSM_OFF_FLAGS, 8'h00);
    endtask

    task automatic t_wdog;
        @(posedge mclk); wdo <= 1'h1;
        tick(3);
        chk(srst, 1'h1);
        @(posedge mclk); wde <= 1'h1;
        @(posedge mclk); wdo <= 1'h0; wde <= 1'h0;
        wait_run(n);
        chk(n >= STB + 5 && n <= STB + 7, 1'h1);
        rreg(RSM_OFF_FLAGS, 8'h20);
    endtask

    task automatic t_pin;
        @(posedge mclk); pull <= 1'h1;
        tick(20); @(posedge mclk); pull <= 1'h0;
        tick(60);
        chk(srst, 1'h1);
        @(posedge mclk); pull <= 1'h1;
        tick(200);
        chk(srst, 1'h0);
        @(posedge mclk); pull <= 1'h0;
        wait_run(n);
        rreg(RSM_OFF_FLAGS, 8'h60);
        @(posedge mclk); dbg <= 1'h1;
        @(posedge mclk); dbg <= 1'h0;
        wait_run(n);
        rreg(RSM_OFF_FLAGS, 8'h70);
    endtask

    task automatic t_brown;
        wreg(RSM_OFF_BROWN, 8'h01);
        sag <= 1'h1;
        tick(10);
        chk(srst, 1'h1);
        wreg(RSM_OFF_BROWN, 8'h1A);
        tick(5);
        chk(srst, 1'h0);
        @(posedge mclk); sag <= 1'h0;
        wait_run(n);
        chk(thr, 4'hD);
        rreg(RSM_OFF_FLAGS, 8'h78);
        wreg(RSM_OFF_BROWN, 8'h1C);
        rreg(RSM_OFF_BROWN, 8'h1A);
    endtask

    task automatic t_warn;
        wreg(RSM_OFF_WARN, 8'h1D);
        tick(1);
        chk({wen, lvl, wref}, 6'h3B);
        @(posedge mclk); wbl <= 1'h1;
        tick(6);
        rreg(RSM_OFF_WARN, 8'h3D);
        // The set still active in the clearing cycle wins over the clear
        wreg(RSM_OFF_WARN, 8'h0D);
        rreg(RSM_OFF_WARN, 8'h2D);
        wreg(RSM_OFF_WARN, 8'h0D);
        tick(6);
        rreg(RSM_OFF_WARN, 8'h0D);
        @(posedge mclk); wbl <= 1'h0;
    endtask

    task automatic t_stop;
        wreg(RSM_OFF_BROWN, 8'h81);
        wreg(RSM_OFF_PCTL, RSM_PCTL_STOP);
        tick(1);
        chk({boen, stp}, 2'h1);
        @(posedge mclk); wake <= 1'h1;
        @(posedge mclk); wake <= 1'h0;
        tick(1);
        chk({boen, stp}, 2'h2);
        rreg(RSM_OFF_PCTL, 8'h00);
        wreg(RSM_OFF_PCTL, RSM_PCTL_IDLE);
        tick(1);
        chk({idl, stp}, 2'h2);
        @(posedge mclk); wake <= 1'h1;
        @(posedge mclk); wake <= 1'h0;
        tick(1);
        chk({idl, stp}, 2'h0);
        // Without re-arm the detector stays off after the wake
        wreg(RSM_OFF_BROWN, 8'h01);
        wreg(RSM_OFF_PCTL, RSM_PCTL_STOP);
        @(posedge mclk); wake <= 1'h1;
        @(posedge mclk); wake <= 1'h0;
        tick(1);
        chk({boen, stp}, 2'h0);
    endtask

    // Clock enable low freezes every flop, reset causes included
    task automatic t_freeze;
        wreg(RSM_OFF_FLAGS, 8'h00);
        @(posedge mclk); ce <= 1'h0; dbg <= 1'h1;
        @(posedge mclk); dbg <= 1'h0;
        @(posedge mclk); ce <= 1'h1;
        tick(2);
        chk(srst, 1'h1);
        rreg(RSM_OFF_FLAGS, 8'h00);
    endtask

    // Hang guard, well above the fewer than a thousand cycles the run needs
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 6000)
        begin
            mismatches++;
            stop_test;
        end
    end

    initial
    begin
        {wr, rd, wdo, wde, dbg, pull, sag, wbl, wake} = '0;
        rstn = 1'h0; addr = 8'h00; wdata = 8'h00;
        ce = 1'h1;
        mismatches = 0; n_checks = 0; cyc = 0;
        repeat (4) @(posedge mclk);
        rstn <= 1'h1;
        t_por; t_wdog; t_pin; t_brown; t_warn; t_stop; t_freeze;
        stop_test;
    end
endmodule // tb_rsm_top
`default_nettype wire
